/* File: pkg/sioc_pkg.sv */
// sioc_pkg: constants for the short i/o location and clock gating block
// assumes a 16-bit register port and a single master clock domain
package sioc_pkg;

  // register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // register indices on the plain register port
  localparam logic [ADDR_W-1:0] ADDR_PCE      = 8'h0c;  // peripheral clock enables
  localparam logic [ADDR_W-1:0] ADDR_LOC_HIGH = 8'h0d;  // short i/o location high
  localparam logic [ADDR_W-1:0] ADDR_LOC_LOW  = 8'h0e;  // short i/o location low
  localparam logic [ADDR_W-1:0] ADDR_CLK_CTRL = 8'h0f;  // clock output / emulation controls
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = 8'h10;  // power mode and debug state

  // field layout
  localparam int PCE_PWM_A_BIT    = 0;
  localparam int LOC_HIGH_W       = 2;   // address bits 23..22
  localparam int LOC_LOW_W        = 16;  // address bits 21..6
  localparam int SHORT_OFFSET_W   = 6;   // bits supplied by the instruction
  localparam int SHORT_ADDR_W     = LOC_HIGH_W + LOC_LOW_W + SHORT_OFFSET_W;
  localparam int CTRL_CLKOUT_DIS  = 0;
  localparam int CTRL_EMU_EN      = 1;

  // reset values
  localparam logic [DATA_W-1:0]     PCE_RESET       = 16'hffff;
  localparam logic [LOC_HIGH_W-1:0] LOC_HIGH_RESET  = 2'h3;      // top of memory
  localparam logic [LOC_LOW_W-1:0]  LOC_LOW_RESET   = 16'hffff;  // top of memory
  localparam logic [DATA_W-1:0]     LOC_HIGH_UPPER  = 16'hfffc;  // upper bits read as one
  localparam logic [1:0]            CLK_CTRL_RESET  = 2'h0;
  localparam logic [DATA_W-1:0]     READ_ZERO       = 16'h0000;

  // clocking figures
  localparam int MASTER_CLK_MAX_MHZ = 120;
  localparam int SYS_CLK_DIVIDE     = 2;
  localparam int SYS_CLK_MAX_MHZ    = MASTER_CLK_MAX_MHZ / SYS_CLK_DIVIDE;

  // delay from a location write to its use by short i/o accesses, in cycles
  localparam int SHORT_IO_DELAY_CYCLES = 3;

  // gated clock outputs of the divider
  localparam int NUM_CLK   = 5;
  localparam int CLK_CORE  = 0;
  localparam int CLK_PERI  = 1;
  localparam int CLK_PWM_A = 2;
  localparam int CLK_EMU   = 3;
  localparam int CLK_OUT   = 4;

  // power modes
  typedef enum logic [1:0] {
    SIOC_RUN  = 2'b00,
    SIOC_WAIT = 2'b01,
    SIOC_STOP = 2'b10
  } sioc_mode_e;

endpackage

/* File: logic/sioc_clk_div.sv */
// sioc_clk_div: halves the master clock and gates each derived clock by its enable
// assumes enables come from logic on the same master clock
`timescale 1ns/1ns
module sioc_clk_div
  import sioc_pkg::*;
#(
  parameter int N = NUM_CLK
) (
  input  wire logic         clk,       // master clock
  input  wire logic         sys_rst,   // async reset, active high
  input  wire logic [N-1:0] clk_en,    // per-clock run enables
  output logic      [N-1:0] clk_gated  // half-rate gated clocks
);

  logic         phase;
  logic         next_phase;
  logic [N-1:0] next_clk_gated;

  // divide by two: phase toggles on every rising master edge
  always_comb begin
    next_phase = ~phase;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= 1'b0;
    end else begin
      phase <= next_phase;
    end
  end

  // enables are looked at only when a clock is about to rise, so a
  // change never clips a high phase short (no runt pulses)
  for (genvar i = 0; i < N; i++) begin : g_gate
    always_comb begin
      next_clk_gated[i] = phase ? 1'b0 : clk_en[i];
    end

    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        clk_gated[i] <= 1'b0;
      end else begin
        clk_gated[i] <= next_clk_gated[i];
      end
    end
  end

endmodule

/* File: logic/sioc_top.sv */
// sioc_top: short i/o location registers, peripheral clock enables and power modes
// assumes a core on clk that issues stop/wait requests and short i/o offsets
`timescale 1ns/1ns
module sioc_top
  import sioc_pkg::*;
#(
  parameter int PIPE_STAGES = SHORT_IO_DELAY_CYCLES - 1
) (
  input  wire logic                      clk,              // master clock, up to 120 mhz
  input  wire logic                      sys_rst,          // async reset, active high
  input  wire logic [ADDR_W-1:0]         reg_addr,         // register index
  input  wire logic [DATA_W-1:0]         reg_wdata,        // write data
  input  wire logic                      reg_wr,           // write strobe
  input  wire logic                      reg_rd,           // read strobe
  output logic      [DATA_W-1:0]         reg_rdata,        // read data, cycle after strobe
  input  wire logic                      short_io_valid,   // short i/o access request
  input  wire logic [SHORT_OFFSET_W-1:0] short_io_offset,  // low address bits from opcode
  output logic      [SHORT_ADDR_W-1:0]   short_io_address, // full 24-bit address
  output logic                           short_io_strobe,  // address valid pulse
  input  wire logic                      external_mode_bit,// from operating mode register
  output logic                           debug_access_block,// debug port barred from emu regs
  input  wire logic                      stop_req,         // core executed stop
  input  wire logic                      wait_req,         // core executed wait
  input  wire logic                      periph_irq,       // unmasked peripheral interrupt
  input  wire logic                      watchdog_reset,   // watchdog reset request
  input  wire logic                      can_rx_pin,       // can receive activity, async
  input  wire logic                      nonclocked_irq,   // non-clocked interrupt, async
  output logic                           core_clk,         // core and memory clock
  output logic                           periph_clk,       // peripheral bus clock
  output logic                           pwm_a_clk,        // pwm a peripheral clock
  output logic                           emu_clk,          // emulation clock
  output logic                           clk_out           // clock output pin
);

  // register state
  logic [DATA_W-1:0]     pce;
  logic [DATA_W-1:0]     next_pce;
  logic [LOC_HIGH_W-1:0] loc_high;
  logic [LOC_HIGH_W-1:0] next_loc_high;
  logic [LOC_LOW_W-1:0]  loc_low;
  logic [LOC_LOW_W-1:0]  next_loc_low;
  logic [1:0]            clk_ctrl;
  logic [1:0]            next_clk_ctrl;
  logic [DATA_W-1:0]     next_reg_rdata;

  // short i/o pipeline state
  localparam int LOC_W = LOC_HIGH_W + LOC_LOW_W;
  logic [LOC_W-1:0]        loc_pipe [PIPE_STAGES];
  logic [LOC_W-1:0]        next_loc_pipe [PIPE_STAGES];
  logic [LOC_W-1:0]        loc_eff;
  logic [SHORT_ADDR_W-1:0] next_short_io_address;
  logic                    next_short_io_strobe;
  logic                    next_debug_access_block;

  // power mode state
  sioc_mode_e mode;
  sioc_mode_e next_mode;
  logic       can_meta;
  logic       can_sync;
  logic       nci_meta;
  logic       nci_sync;
  logic       can_prev;
  logic       next_can_prev;
  logic       stop_wake;
  logic [NUM_CLK-1:0] clk_en;
  logic [NUM_CLK-1:0] clk_gated;

  // register writes; the pair only stores what software writes
  always_comb begin
    next_pce      = pce;
    next_loc_high = loc_high;
    next_loc_low  = loc_low;
    next_clk_ctrl = clk_ctrl;
    if (reg_wr) begin
      case (reg_addr)
        ADDR_PCE: begin
          next_pce = reg_wdata;
        end
        ADDR_LOC_HIGH: begin
          next_loc_high = reg_wdata[LOC_HIGH_W-1:0];
        end
        ADDR_LOC_LOW: begin
          next_loc_low = reg_wdata[LOC_LOW_W-1:0];
        end
        ADDR_CLK_CTRL: begin
          next_clk_ctrl = reg_wdata[1:0];
        end
        default: begin
          next_pce = pce;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pce      <= PCE_RESET;
      loc_high <= LOC_HIGH_RESET;
      loc_low  <= LOC_LOW_RESET;
      clk_ctrl <= CLK_CTRL_RESET;
    end else begin
      pce      <= next_pce;
      loc_high <= next_loc_high;
      loc_low  <= next_loc_low;
      clk_ctrl <= next_clk_ctrl;
    end
  end

  // read mux, registered so data stands in the cycle after the strobe
  always_comb begin
    next_reg_rdata = READ_ZERO;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_PCE: begin
          next_reg_rdata = pce;
        end
        ADDR_LOC_HIGH: begin
          next_reg_rdata = LOC_HIGH_UPPER | {{(DATA_W-LOC_HIGH_W){1'b0}}, loc_high};
        end
        ADDR_LOC_LOW: begin
          next_reg_rdata = loc_low;
        end
        ADDR_CLK_CTRL: begin
          next_reg_rdata = {{(DATA_W-2){1'b0}}, clk_ctrl};
        end
        ADDR_STATUS: begin
          next_reg_rdata = {{(DATA_W-3){1'b0}}, debug_access_block, mode};
        end
        default: begin
          next_reg_rdata = READ_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= READ_ZERO;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // write-to-use delay
  // the stored pair is seen one cycle after the write, the pipe adds the rest;
  // software that reads back sees the new value earlier than accesses do
  for (genvar s = 0; s < PIPE_STAGES; s++) begin : g_pipe
    // the head stage loads the stored pair; no stage ever indexes below zero
    if (s == 0) begin : g_head
      always_comb begin
        next_loc_pipe[s] = {loc_high, loc_low};
      end
    end else begin : g_tail
      always_comb begin
        next_loc_pipe[s] = loc_pipe[s-1];
      end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        loc_pipe[s] <= {LOC_HIGH_RESET, LOC_LOW_RESET};
      end else begin
        loc_pipe[s] <= next_loc_pipe[s];
      end
    end
  end

  assign loc_eff = loc_pipe[PIPE_STAGES-1];

  always_comb begin
    next_short_io_address   = short_io_address;
    next_short_io_strobe    = short_io_valid;
    next_debug_access_block = external_mode_bit &&
                              (loc_eff != {LOC_HIGH_RESET, LOC_LOW_RESET});
    if (short_io_valid) begin
      next_short_io_address = {loc_eff, short_io_offset};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      short_io_address   <= {SHORT_ADDR_W{1'b0}};
      short_io_strobe    <= 1'b0;
      debug_access_block <= 1'b0;
    end else begin
      short_io_address   <= next_short_io_address;
      short_io_strobe    <= next_short_io_strobe;
      debug_access_block <= next_debug_access_block;
    end
  end

  // two-flop synchronisers for the asynchronous wake pins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      can_meta <= 1'b0;
      can_sync <= 1'b0;
      nci_meta <= 1'b0;
      nci_sync <= 1'b0;
    end else begin
      can_meta <= can_rx_pin;
      can_sync <= can_meta;
      nci_meta <= nonclocked_irq;
      nci_sync <= nci_meta;
    end
  end

  // stop wake sources
  // can activity is a bit edge; the message in flight is lost since the
  // peripheral clock was off when it began
  always_comb begin
    next_can_prev = can_sync;
    stop_wake     = (can_sync ^ can_prev) | nci_sync | watchdog_reset;
  end

  always_comb begin
    next_mode = mode;
    case (mode)
      SIOC_RUN: begin
        if (stop_req) begin
          next_mode = SIOC_STOP;
        end else if (wait_req) begin
          next_mode = SIOC_WAIT;
        end
      end
      SIOC_WAIT: begin
        if (periph_irq || watchdog_reset) begin
          next_mode = SIOC_RUN;
        end
      end
      SIOC_STOP: begin
        if (stop_wake) begin
          next_mode = SIOC_RUN;
        end
      end
      default: begin
        next_mode = SIOC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode     <= SIOC_RUN;
      can_prev <= 1'b0;
    end else begin
      mode     <= next_mode;
      can_prev <= next_can_prev;
    end
  end

  always_comb begin
    clk_en            = {NUM_CLK{1'b0}};
    clk_en[CLK_CORE]  = (mode == SIOC_RUN);
    clk_en[CLK_PERI]  = (mode != SIOC_STOP);
    clk_en[CLK_PWM_A] = (mode != SIOC_STOP) && pce[PCE_PWM_A_BIT];
    clk_en[CLK_EMU]   = clk_ctrl[CTRL_EMU_EN] && (mode == SIOC_RUN);
    clk_en[CLK_OUT]   = !clk_ctrl[CTRL_CLKOUT_DIS] && (mode != SIOC_STOP);
  end

  sioc_clk_div #(
    .N (NUM_CLK)
  ) u_clk_div (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .clk_gated (clk_gated)
  );

  assign core_clk   = clk_gated[CLK_CORE];
  assign periph_clk = clk_gated[CLK_PERI];
  assign pwm_a_clk  = clk_gated[CLK_PWM_A];
  assign emu_clk    = clk_gated[CLK_EMU];
  assign clk_out    = clk_gated[CLK_OUT];

endmodule

/* File: test/sioc_top_sva.sv */
// sioc_top_chk: port assertions for the short i/o location block
// assumes a bind into sioc_top, one clock, async active-high reset
`timescale 1ns/1ns
module sioc_top_chk
  import sioc_pkg::*;
#(
  parameter int PIPE_STAGES = SHORT_IO_DELAY_CYCLES - 1
) (
  input wire logic                      clk,                // clock
  input wire logic                      sys_rst,            // reset
  input wire logic [ADDR_W-1:0]         reg_addr,           // index
  input wire logic [DATA_W-1:0]         reg_wdata,          // wdata
  input wire logic                      reg_wr,             // write
  input wire logic                      reg_rd,             // read
  input wire logic [DATA_W-1:0]         reg_rdata,          // rdata
  input wire logic                      short_io_valid,     // request
  input wire logic [SHORT_OFFSET_W-1:0] short_io_offset,    // offset
  input wire logic [SHORT_ADDR_W-1:0]   short_io_address,   // address
  input wire logic                      short_io_strobe,    // strobe
  input wire logic                      external_mode_bit,  // ext mode
  input wire logic                      debug_access_block, // block
  input wire logic                      core_clk,           // core
  input wire logic                      periph_clk,         // periph
  input wire logic                      pwm_a_clk,          // pwm a
  input wire logic                      emu_clk             // emu
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // writes ahead of a request are seen three cycles on, not sooner
  AST_HIGH_ONES: assert property (
    (reg_rd && reg_addr == ADDR_LOC_HIGH) |=> reg_rdata[15:2] == 14'h3fff)
    else $error("high location upper bits not one");
  AST_OFFSET: assert property (
    short_io_valid |=> short_io_strobe && short_io_address[5:0] == $past(short_io_offset))
    else $error("short offset or strobe wrong");
  AST_LOW_DELAY: assert property (
    (reg_wr && reg_addr == ADDR_LOC_LOW) ##3 short_io_valid
      |=> short_io_address[21:6] == $past(reg_wdata, 4))
    else $error("low location not used after three cycles");
  AST_HIGH_DELAY: assert property (
    (reg_wr && reg_addr == ADDR_LOC_HIGH) ##3 short_io_valid
      |=> short_io_address[23:22] == $past(reg_wdata[1:0], 4))
    else $error("high location not used after three cycles");
  AST_PWM_GATE: assert property (
    pwm_a_clk |-> periph_clk)
    else $error("pwm a clock out of step");
  AST_CORE_HALF: assert property (
    core_clk |=> !core_clk && !periph_clk)
    else $error("core clock not half rate");
  AST_EMU_RUN: assert property (
    emu_clk |-> core_clk && periph_clk)
    else $error("emulation clock outside run");
  AST_DEBUG_BLOCK: assert property (
    !external_mode_bit |=> !debug_access_block)
    else $error("debug blocked without external mode");
endmodule

bind sioc_top sioc_top_chk #(.PIPE_STAGES(PIPE_STAGES)) sioc_top_chk_i (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .short_io_valid(short_io_valid), .short_io_offset(short_io_offset),
  .short_io_address(short_io_address), .short_io_strobe(short_io_strobe),
  .external_mode_bit(external_mode_bit), .debug_access_block(debug_access_block),
  .core_clk(core_clk), .periph_clk(periph_clk), .pwm_a_clk(pwm_a_clk),
  .emu_clk(emu_clk)
);

/* File: test/sioc_top_tb_top.sv */
// sioc_top_tb_top: self-checking bench for the short i/o location block
// assumes sioc_top alone on a 125 mhz clock, every input driven here
`timescale 1ns/1ns
module sioc_top_tb_top
  import sioc_pkg::*;
;
  logic        clk = 1'b0, sys_rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, cur_lo, d, pce;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, short_io_valid = 1'b0;
  logic [5:0]  short_io_offset = 6'h00, off;
  logic        external_mode_bit = 1'b0, stop_req = 1'b0, wait_req = 1'b0;
  logic        periph_irq = 1'b0, watchdog_reset = 1'b0, can_rx_pin = 1'b0;
  logic        nonclocked_irq = 1'b0, short_io_strobe, debug_access_block;
  logic        core_clk, periph_clk, pwm_a_clk, emu_clk, clk_out;
  logic [23:0] short_io_address, sa;
  logic [4:0]  seen;
  logic [1:0]  cur_hi, ctl;
  int          err_total = 0, samples_checked = 0, gap;

  // 8 ns period
  always #4 clk = ~clk;

  sioc_top sioc_top_i (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .short_io_valid(short_io_valid), .short_io_offset(short_io_offset),
    .short_io_address(short_io_address), .short_io_strobe(short_io_strobe),
    .external_mode_bit(external_mode_bit), .debug_access_block(debug_access_block),
    .stop_req(stop_req), .wait_req(wait_req), .periph_irq(periph_irq),
    .watchdog_reset(watchdog_reset), .can_rx_pin(can_rx_pin),
    .nonclocked_irq(nonclocked_irq), .core_clk(core_clk), .periph_clk(periph_clk),
    .pwm_a_clk(pwm_a_clk), .emu_clk(emu_clk), .clk_out(clk_out)
  );

  // comparison and verdict
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic report_and_stop();
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // full short address from the pair and the opcode offset
  function automatic logic [23:0] ea(input logic [1:0] h, input logic [15:0] l);
    return {h, l, off};
  endfunction

  // register bus cycles; read data only stand the cycle after the strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask

  // write, then a short request sampled g cycles after the write
  task automatic wsio(input logic [7:0] a, input logic [15:0] v, input int g);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    repeat (g) begin
      @(posedge clk);
      reg_wr <= 1'b0;
    end
    short_io_valid <= 1'b1;
    short_io_offset <= off;
    @(posedge clk);
    short_io_valid <= 1'b0;
    #1 sa = short_io_address;
    chk(short_io_strobe, 1'b1);
  endtask

  // collects which clocks went high over eight cycles
  task automatic watch();
    seen = 5'h00;
    repeat (8) begin
      @(posedge clk);
      #1 seen = seen | {clk_out, emu_clk, pwm_a_clk, periph_clk, core_clk};
    end
  endtask

  task automatic req(input logic s, input logic w);
    @(posedge clk);
    stop_req <= s;
    wait_req <= w;
    @(posedge clk);
    stop_req <= 1'b0;
    wait_req <= 1'b0;
  endtask

  // bounded wait for the core clock to come back
  task automatic wake_wait();
    int n = 0;
    while (core_clk !== 1'b1 && n < 16) begin
      @(posedge clk);
      #1 n++;
    end
    if (core_clk !== 1'b1) begin
      err_total++;
      report_and_stop();
    end
  endtask

  initial begin
    void'($urandom(81));
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    external_mode_bit <= 1'b1;
    rdc(ADDR_LOC_HIGH, 16'hffff);
    rdc(ADDR_LOC_LOW, 16'hffff);
    rdc(ADDR_PCE, 16'hffff);
    rdc(8'h33, 16'h0000);
    off = 6'h2a;
    wsio(8'h40, 16'h5555, 1);
    chk(sa, ea(2'h3, 16'hffff));
    chk(debug_access_block, 1'b0);
    // random pair writes, requests one to three cycles behind them
    cur_hi = 2'h3;
    cur_lo = 16'hffff;
    for (int i = 0; i < 12; i++) begin
      d = 16'($urandom());
      off = 6'($urandom());
      gap = 1 + i % 3;
      wsio(i[0] ? ADDR_LOC_HIGH : ADDR_LOC_LOW, d, gap);
      if (gap == 3) {cur_hi, cur_lo} = i[0] ? {d[1:0], cur_lo} : {cur_hi, d};
      chk(sa, ea(cur_hi, cur_lo));
      {cur_hi, cur_lo} = i[0] ? {d[1:0], cur_lo} : {cur_hi, d};
    end
    rdc(ADDR_LOC_HIGH, {14'h3fff, cur_hi});
    rdc(ADDR_LOC_LOW, cur_lo);
    // debug blocking off top of memory
    wr(ADDR_LOC_HIGH, 16'h0001);
    repeat (6) @(posedge clk);
    #1 chk(debug_access_block, 1'b1);
    @(posedge clk);
    external_mode_bit <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(debug_access_block, 1'b0);
    wr(ADDR_LOC_HIGH, 16'h0003);
    wr(ADDR_LOC_LOW, 16'hffff);
    rdc(ADDR_LOC_HIGH, 16'hffff);
    external_mode_bit <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk(debug_access_block, 1'b0);
    // every control combination, the pwm a enable set on the even passes only
    for (int k = 0; k < 4; k++) begin
      ctl = 2'(k);
      pce = (16'($urandom()) & 16'hfffe) | {15'h0000, !k[0]};
      wr(ADDR_PCE, pce);
      wr(ADDR_CLK_CTRL, {14'h0000, ctl});
      rdc(ADDR_PCE, pce);
      watch();
      chk(seen, {~ctl[0], ctl[1], pce[0], 2'b11});
    end
    wr(ADDR_PCE, 16'hffff);
    wr(ADDR_CLK_CTRL, 16'h0000);
    // wait: core off, can and non-clocked stop wake sources ignored, irq wakes
    req(1'b0, 1'b1);
    watch();
    chk(seen, 5'b10110);
    rdc(ADDR_STATUS, 16'h0001);
    can_rx_pin <= ~can_rx_pin;
    nonclocked_irq <= 1'b1;
    req(1'b1, 1'b0);
    repeat (6) @(posedge clk);
    nonclocked_irq <= 1'b0;
    rdc(ADDR_STATUS, 16'h0001);
    periph_irq <= 1'b1;
    wake_wait();
    @(posedge clk);
    periph_irq <= 1'b0;
    rdc(ADDR_STATUS, 16'h0000);
    // stop: all clocks off, left only by its own wake sources
    for (int s = 0; s < 3; s++) begin
      req(1'b1, s == 2);
      periph_irq <= 1'b1;
      watch();
      chk(seen, 5'h00);
      rdc(ADDR_STATUS, 16'h0002);
      @(posedge clk);
      periph_irq <= 1'b0;
      nonclocked_irq <= (s == 0);
      watchdog_reset <= (s == 1);
      can_rx_pin <= (s == 2) ? ~can_rx_pin : can_rx_pin;
      wake_wait();
      @(posedge clk);
      nonclocked_irq <= 1'b0;
      watchdog_reset <= 1'b0;
      rdc(ADDR_STATUS, 16'h0000);
    end
    wr(ADDR_STATUS, 16'hffff);
    rdc(ADDR_STATUS, 16'h0000);
    report_and_stop();
  end
endmodule
